//--- hdl/dpr_page_pkg.sv
// Constants, types and register map of the paged dual-port RAM access block
package dpr_page_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_BASE = 5'h04;
  localparam logic [4:0] OFS_ACC1 = 5'h08;
  localparam logic [4:0] OFS_ACC2 = 5'h0C;
  localparam logic [4:0] OFS_CMD = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_PAGE = 5'h18;
  localparam logic [4:0] OFS_INTERRUPT_STACK = 5'h1C;
  // CTRL fields
  localparam int CTRL_SUB_HANDLER = 0;
  localparam int CTRL_XFER_HANDLER = 1;
  // CMD fields: opcode in [3:0], signed constant in [31:16]
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_CONST_LSB = 16;
  // STATUS fields
  localparam int ST_BUSY = 0;
  localparam int ST_CC_LOW = 1;
  localparam int ST_CC_HIGH = 2;
  localparam int ST_STOPPED = 3;
  localparam int ST_SUB_ERR = 4;
  localparam int ST_XFER_ERR = 5;
  // INTERRUPT_STACK fields
  localparam int IST_XFER = 0;
  localparam int IST_SUB = 1;
  // Reset values
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Page window and access limits (20-bit absolute addresses)
  localparam logic [19:0] WIN_LO = 20'hF_F400;
  localparam logic [19:0] WIN_HI_BYTE = 20'hF_FBFF;
  localparam logic [19:0] WIN_HI_WORD = 20'hF_FBFE;
  localparam logic [19:0] WIN_HI_DWORD = 20'hF_FBFC;
  localparam logic [19:0] WIN_HI_TS = 20'hF_FBFF;
  localparam logic [19:0] PAGE_SPAN = 20'h0_0800;
  localparam logic [15:0] PAGE_MAX = 16'h00FF;

  typedef enum logic [3:0] {
    OP_NONE, OP_OPEN_PAGE, OP_BYTE_LOAD, OP_WORD_LOAD, OP_DWORD_LOAD,
    OP_BYTE_STORE, OP_WORD_STORE, OP_DWORD_STORE, OP_TEST_AND_SET
  } op_e;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} size_e;

  // Backplane request towards the dual-port RAM modules
  typedef struct packed {
    logic req;
    logic we;
    logic sel;
    size_e size;
    logic [19:0] addr;
    logic [31:0] wdata;
  } bp_req_s;

  // Backplane answer from the addressed module
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } bp_rsp_s;
endpackage : dpr_page_pkg

//--- hdl/dpr_page_access.sv
// Paged dual-port RAM access engine with Wishbone register slave
// What this block does
// RQ1 - Access address is base register plus signed 16-bit operation constant.
// RQ2 - Window F F400H to F FBFFH shows one of 256 byte or word pages.
// RQ3 - One page spans at most 2K addresses inside the window.
// RQ4 - Select write and page access run as one locked, uninterruptible sequence.
// RQ5 - Page open copies accumulator low word into page register; valid 0 to 255.
// RQ6 - Every page access first writes the page register to module select registers.
// RQ7 - Page register changes only on page open, nothing else touches it.
// RQ8 - Page number above 255 raises substitution error; handler call or stop.
// RQ9 - Test-and-set uses low byte of addressed word; writes slot id when zero.
// RQ10 - Occupancy read and conditional write form one indivisible locked operation.
// RQ11 - Flags: 00 claimed, high set when own id, low set when other id.
// RQ12 - Sharing CPUs claim with test-and-set and release by writing zero.
// RQ13 - Test-and-set off module or outside window raises transfer error.
// RQ14 - Byte load fills low byte and clears all higher accumulator bits.
// RQ15 - Word load fills low half and clears upper accumulator half.
// RQ16 - Double-word load fills whole accumulator; loads save old value in secondary.
// RQ17 - Stores write low byte, low half or whole primary accumulator.
// RQ18 - Byte to F FBFFH, word to F FBFEH, double word to F FBFCH.
// RQ19 - Out-of-range load or store raises transfer error; handler call or stop.
// RQ20 - Page register clears to zero on reset.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module dpr_page_access (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Backplane master
  output dpr_page_pkg::bp_req_s bp_o,
  output logic bp_lock_o,
  input wire dpr_page_pkg::bp_rsp_s bp_i,
  // Own slot identifier and error reaction
  input wire logic [7:0] slot_id_i,
  output logic sub_handler_call_o,
  output logic xfer_handler_call_o,
  output logic stopped_o
);
  typedef enum logic [2:0] {S_IDLE, S_SEL, S_ACC, S_TS_WR} state_e;

  state_e state;
  logic [1:0] ctrl;
  logic [19:0] base;
  logic [31:0] acc1;
  logic [31:0] acc2;
  logic [7:0] page;
  dpr_page_pkg::op_e op;
  logic [15:0] cmd_const;
  logic cc_low;
  logic cc_high;
  logic stopped;
  logic sub_err;
  logic xfer_err;
  logic [1:0] interrupt_stack;
  logic [21:0] sum;
  logic wr_hit;
  logic go;
  logic go_bad_page;
  logic go_bad_range;
  logic sub_evt;
  logic xfer_evt;
  logic load_done;
  logic ts_read_done;
  logic [31:0] next_acc1;
  dpr_page_pkg::op_e cmd_op;

  function automatic logic in_window(input logic [21:0] a, input logic [19:0] hi);
    in_window = (a[21:20] == 2'b00) && (a[19:0] >= dpr_page_pkg::WIN_LO) && (a[19:0] <= hi);
  endfunction : in_window

  function automatic logic [19:0] limit_of(input dpr_page_pkg::op_e o);
    case (o)
      dpr_page_pkg::OP_BYTE_LOAD, dpr_page_pkg::OP_BYTE_STORE: limit_of = dpr_page_pkg::WIN_HI_BYTE;
      dpr_page_pkg::OP_WORD_LOAD, dpr_page_pkg::OP_WORD_STORE: limit_of = dpr_page_pkg::WIN_HI_WORD;
      dpr_page_pkg::OP_TEST_AND_SET: limit_of = dpr_page_pkg::WIN_HI_TS;
      default: limit_of = dpr_page_pkg::WIN_HI_DWORD;
    endcase
  endfunction : limit_of

  function automatic dpr_page_pkg::size_e size_of(input dpr_page_pkg::op_e o);
    case (o)
      dpr_page_pkg::OP_BYTE_LOAD, dpr_page_pkg::OP_BYTE_STORE: size_of = dpr_page_pkg::SZ_BYTE;
      dpr_page_pkg::OP_DWORD_LOAD, dpr_page_pkg::OP_DWORD_STORE: size_of = dpr_page_pkg::SZ_DWORD;
      default: size_of = dpr_page_pkg::SZ_WORD;
    endcase
  endfunction : size_of

  // Wishbone write strobe and command decode
  assign wr_hit = cyc_i && stb_i && we_i && !ack_o;
  assign cmd_op = dpr_page_pkg::op_e'(dat_i[dpr_page_pkg::CMD_OP_LSB +: 4]);
  assign go = wr_hit && (adr_i == dpr_page_pkg::OFS_CMD) && (state == S_IDLE) && !stopped
              && (cmd_op != dpr_page_pkg::OP_NONE);
  // Base stays frozen while busy, but the constant comes from dat_i, so the sum is valid only in the command write cycle
  assign sum = {2'b00, base}
               + {{6{dat_i[dpr_page_pkg::CMD_CONST_LSB + 15]}},
                  dat_i[dpr_page_pkg::CMD_CONST_LSB +: 16]}; // [RQ1]
  assign go_bad_page = go && (cmd_op == dpr_page_pkg::OP_OPEN_PAGE)
                       && (acc1[15:0] > dpr_page_pkg::PAGE_MAX); // [RQ8]
  assign go_bad_range = go && (cmd_op != dpr_page_pkg::OP_OPEN_PAGE) // [RQ2] [RQ3]
                        && !in_window(sum, limit_of(cmd_op)); // [RQ18] [RQ13] [RQ19]
  assign sub_evt = go_bad_page;
  assign xfer_evt = go_bad_range
                    || (bp_i.err && bp_o.req && (state != S_IDLE)); // [RQ13] [RQ19]
  assign load_done = (state == S_ACC) && bp_i.ack && !bp_o.we
                     && (op != dpr_page_pkg::OP_TEST_AND_SET);
  assign ts_read_done = (state == S_ACC) && bp_i.ack && (op == dpr_page_pkg::OP_TEST_AND_SET);

  // Wishbone answer: one cycle after the strobe, unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !we_i && !ack_o) begin
        if (adr_i == dpr_page_pkg::OFS_CTRL) begin
          dat_o <= {30'h0000_0000, ctrl};
        end else if (adr_i == dpr_page_pkg::OFS_BASE) begin
          dat_o <= {12'h000, base};
        end else if (adr_i == dpr_page_pkg::OFS_ACC1) begin
          dat_o <= acc1;
        end else if (adr_i == dpr_page_pkg::OFS_ACC2) begin
          dat_o <= acc2;
        end else if (adr_i == dpr_page_pkg::OFS_CMD) begin
          dat_o <= {cmd_const, 12'h000, op};
        end else if (adr_i == dpr_page_pkg::OFS_STATUS) begin
          dat_o <= {26'h000_0000, xfer_err, sub_err, stopped, cc_high, cc_low,
                    state != S_IDLE};
        end else if (adr_i == dpr_page_pkg::OFS_PAGE) begin
          dat_o <= {24'h00_0000, page};
        end else if (adr_i == dpr_page_pkg::OFS_INTERRUPT_STACK) begin
          dat_o <= {30'h0000_0000, interrupt_stack};
        end else begin
          dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // Software configuration; base is locked while an operation runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= dpr_page_pkg::CTRL_RESET;
      base <= 20'h0_0000;
    end else if (wr_hit && (adr_i == dpr_page_pkg::OFS_CTRL) && sel_i[0]) begin
      ctrl <= dat_i[1:0];
    end else if (wr_hit && (adr_i == dpr_page_pkg::OFS_BASE) && (state == S_IDLE)) begin
      base <= dat_i[19:0];
    end
  end

  // Page number register: only a valid page open touches it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page <= dpr_page_pkg::PAGE_RESET; // [RQ20]
    end else if (go && (cmd_op == dpr_page_pkg::OP_OPEN_PAGE) && !go_bad_page) begin
      page <= acc1[7:0]; // [RQ5] [RQ7]
    end
  end

  // Accumulators: loads shift the old primary value into the secondary
  always_comb begin
    next_acc1 = bp_i.rdata;
    case (op)
      dpr_page_pkg::OP_BYTE_LOAD: next_acc1 = {24'h00_0000, bp_i.rdata[7:0]}; // [RQ14]
      dpr_page_pkg::OP_WORD_LOAD: next_acc1 = {16'h0000, bp_i.rdata[15:0]}; // [RQ15]
      default: next_acc1 = bp_i.rdata; // [RQ16]
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc1 <= 32'h0000_0000;
      acc2 <= 32'h0000_0000;
    end else if (load_done) begin
      acc2 <= acc1; // [RQ16]
      acc1 <= next_acc1;
    end else if (wr_hit && (state == S_IDLE) && (adr_i == dpr_page_pkg::OFS_ACC1)) begin
      acc1 <= dat_i;
    end else if (wr_hit && (state == S_IDLE) && (adr_i == dpr_page_pkg::OFS_ACC2)) begin
      acc2 <= dat_i;
    end
  end

  // Sequencer: select write, then the access, all under one bus lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      op <= dpr_page_pkg::OP_NONE;
      cmd_const <= 16'h0000;
      bp_o <= '0;
      cc_low <= 1'b0;
      cc_high <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (go) begin
            op <= cmd_op;
            cmd_const <= dat_i[dpr_page_pkg::CMD_CONST_LSB +: 16];
          end
          if (go && (cmd_op != dpr_page_pkg::OP_OPEN_PAGE) && !go_bad_range) begin
            state <= S_SEL;
            bp_o.req <= 1'b1;
            bp_o.we <= 1'b1;
            bp_o.sel <= 1'b1;
            bp_o.size <= dpr_page_pkg::SZ_BYTE;
            bp_o.addr <= sum[19:0];
            bp_o.wdata <= {24'h00_0000, page}; // [RQ6]
          end
        end
        S_SEL: begin
          if (bp_i.err) begin
            state <= S_IDLE;
            bp_o.req <= 1'b0;
          end else if (bp_i.ack) begin
            state <= S_ACC; // [RQ4]
            bp_o.sel <= 1'b0;
            bp_o.size <= size_of(op);
            bp_o.we <= (op == dpr_page_pkg::OP_BYTE_STORE) || (op == dpr_page_pkg::OP_WORD_STORE)
                       || (op == dpr_page_pkg::OP_DWORD_STORE);
            bp_o.wdata <= (op == dpr_page_pkg::OP_BYTE_STORE) ? {24'h00_0000, acc1[7:0]} :
                          (op == dpr_page_pkg::OP_WORD_STORE) ? {16'h0000, acc1[15:0]} :
                          acc1; // [RQ17]
          end
        end
        S_ACC: begin
          if (bp_i.err) begin
            state <= S_IDLE;
            bp_o.req <= 1'b0;
          end else if (ts_read_done && (bp_i.rdata[7:0] == 8'h00)) begin
            // Keep the high byte of the word intact, claim only the low byte
            state <= S_TS_WR;
            bp_o.we <= 1'b1;
            bp_o.wdata <= {16'h0000, bp_i.rdata[15:8], slot_id_i}; // [RQ9] [RQ10]
            cc_high <= 1'b0;
            cc_low <= 1'b0; // [RQ11]
          end else if (bp_i.ack) begin
            state <= S_IDLE;
            bp_o.req <= 1'b0;
            if (op == dpr_page_pkg::OP_TEST_AND_SET) begin
              cc_high <= (bp_i.rdata[7:0] == slot_id_i); // [RQ11]
              cc_low <= (bp_i.rdata[7:0] != slot_id_i);
            end
          end
        end
        S_TS_WR: begin
          if (bp_i.ack || bp_i.err) begin
            state <= S_IDLE;
            bp_o.req <= 1'b0;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Lock spans select write and access so no other master slips in between
  assign bp_lock_o = (state != S_IDLE); // [RQ4] [RQ10]

  // Error reaction: handler call when loaded, otherwise stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_handler_call_o <= 1'b0;
      xfer_handler_call_o <= 1'b0;
    end else begin
      sub_handler_call_o <= sub_evt && ctrl[dpr_page_pkg::CTRL_SUB_HANDLER]; // [RQ8]
      xfer_handler_call_o <= xfer_evt && ctrl[dpr_page_pkg::CTRL_XFER_HANDLER]; // [RQ13] [RQ19]
    end
  end

  // Sticky flags; a new event wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stopped <= 1'b0;
      sub_err <= 1'b0;
      xfer_err <= 1'b0;
      interrupt_stack <= 2'b00;
    end else begin
      if (wr_hit && (adr_i == dpr_page_pkg::OFS_STATUS)) begin
        stopped <= stopped && !dat_i[dpr_page_pkg::ST_STOPPED];
        sub_err <= sub_err && !dat_i[dpr_page_pkg::ST_SUB_ERR];
        xfer_err <= xfer_err && !dat_i[dpr_page_pkg::ST_XFER_ERR];
      end
      if (wr_hit && (adr_i == dpr_page_pkg::OFS_INTERRUPT_STACK)) begin
        interrupt_stack <= interrupt_stack & ~dat_i[1:0];
      end
      if (sub_evt) begin
        sub_err <= 1'b1;
        if (!ctrl[dpr_page_pkg::CTRL_SUB_HANDLER]) begin
          stopped <= 1'b1; // [RQ8]
          interrupt_stack[dpr_page_pkg::IST_SUB] <= 1'b1;
        end
      end
      if (xfer_evt) begin
        xfer_err <= 1'b1;
        if (!ctrl[dpr_page_pkg::CTRL_XFER_HANDLER]) begin
          stopped <= 1'b1; // [RQ19]
          interrupt_stack[dpr_page_pkg::IST_XFER] <= 1'b1;
        end
      end
    end
  end

  assign stopped_o = stopped;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_addr_formed: assert property ((state == S_ACC) |-> // [RQ1]
    bp_o.addr == 20'(base + {{4{cmd_const[15]}}, cmd_const}))
    else $error("access address differs from base plus constant");
  a_window_hit: assert property ((state == S_ACC) |-> // [RQ2]
    (bp_o.addr >= dpr_page_pkg::WIN_LO) && (bp_o.addr <= dpr_page_pkg::WIN_HI_BYTE))
    else $error("page access outside the window");
  a_page_span: assert property ((state == S_ACC) |-> // [RQ3]
    (bp_o.addr - dpr_page_pkg::WIN_LO) < dpr_page_pkg::PAGE_SPAN)
    else $error("page access beyond 2K span");
  a_select_first: assert property ($rose(state == S_ACC) |-> // [RQ6]
    $past(state == S_SEL) && $past(bp_o.sel) && ($past(bp_o.wdata[7:0]) == page))
    else $error("access not preceded by select write");
  a_lock_held: assert property ((state == S_SEL) ##1 (state == S_ACC) |-> // [RQ4]
    $past(bp_lock_o) && bp_lock_o)
    else $error("lock dropped between select and access");
  a_page_opened: assert property ((go && cmd_op == dpr_page_pkg::OP_OPEN_PAGE // [RQ5]
    && acc1[15:0] <= 16'h00FF) |=> page == $past(acc1[7:0]))
    else $error("page open did not load page register");
  a_page_kept: assert property (!(go && cmd_op == dpr_page_pkg::OP_OPEN_PAGE) |=> // [RQ7]
    $stable(page))
    else $error("page register changed without page open");
  a_sub_error: assert property (go_bad_page |=> // [RQ8]
    (sub_handler_call_o || stopped) && sub_err && $stable(page))
    else $error("bad page number not reported");
  a_ts_claim: assert property ((ts_read_done && bp_i.rdata[7:0] == 8'h00) |=> // [RQ9]
    (state == S_TS_WR) && bp_o.we && (bp_o.wdata[7:0] == $past(slot_id_i)) && !cc_low && !cc_high)
    else $error("free occupancy byte not claimed");
  a_ts_flags: assert property ((ts_read_done && bp_i.rdata[7:0] != 8'h00) |=> // [RQ11]
    (cc_high == ($past(bp_i.rdata[7:0]) == $past(slot_id_i))) && (cc_low == !cc_high))
    else $error("test-and-set flags wrong");
  a_byte_load: assert property ((load_done && op == dpr_page_pkg::OP_BYTE_LOAD) |=> // [RQ14]
    (acc1[31:8] == 24'h00_0000) && (acc2 == $past(acc1)))
    else $error("byte load left upper bits or lost old value");
  a_range_error: assert property (go_bad_range |=> // [RQ19]
    (state == S_IDLE) && !bp_o.req && xfer_err)
    else $error("out of range access not refused");
endmodule : dpr_page_access
`default_nettype wire

//--- verification/dpr_page_partner.sv
// Behavioural dual-port RAM modules with a page select register
`timescale 1ns/10ps
`default_nettype none
module dpr_page_partner (
  // Clock
  input wire logic clk_i,
  // Backplane
  input wire dpr_page_pkg::bp_req_s req_i,
  output var dpr_page_pkg::bp_rsp_s rsp_o,
  // Answer latency and missing module
  input wire logic [2:0] lat_i,
  input wire logic absent_i
);
  logic [7:0] mem [int];
  logic [7:0] page = 8'h00;
  logic [31:0] last = 32'h0000_0000;
  logic [31:0] rv;
  int wt = 0;
  int k;
  initial rsp_o = '0;
  always @(posedge clk_i) begin
    rsp_o.ack <= 1'b0;
    rsp_o.err <= 1'b0;
    // Undriven data lines must not look like the last good value
    rsp_o.rdata <= ~last;
    if (req_i.req && !rsp_o.ack && !rsp_o.err) begin
      if (wt < int'(lat_i)) begin
        wt = wt + 1;
      end else begin
        wt = 0;
        if (absent_i) begin
          rsp_o.err <= 1'b1;
        end else if (req_i.sel) begin
          rsp_o.ack <= 1'b1;
          page = req_i.wdata[7:0];
        end else begin
          rsp_o.ack <= 1'b1;
          rv = 32'h0000_0000;
          for (int i = 0; i < (1 << req_i.size); i++) begin
            k = int'({page, req_i.addr + 20'(i)});
            if (req_i.we) mem[k] = req_i.wdata[8*i +: 8];
            else rv[8*i +: 8] = mem.exists(k) ? mem[k] : 8'h00;
          end
          rsp_o.rdata <= rv;
          last = rv;
        end
      end
    end
  end
endmodule : dpr_page_partner
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the paged dual-port RAM access block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [4:0] adr_i = 5'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o, q;
  logic ack_o, bp_lock_o, sub_call, xfer_call, stopped_o, preq;
  dpr_page_pkg::bp_req_s bp_o;
  dpr_page_pkg::bp_rsp_s bp_i;
  logic [7:0] slot_id_i = 8'h15;
  logic [2:0] lat = 3'h0;
  logic absent = 1'b0;
  int fails = 0, tests_run = 0, seed = 32'he568;
  // Reference model state
  logic [31:0] acc1 = 0, acc2 = 0, base = 0;
  logic [7:0] pg = 0;
  logic [1:0] ctrl = 0, ist = 0;
  logic [5:0] st = 0;
  logic [7:0] mm [int];
  int scall = 0, xcall = 0, ns = 0, nx = 0, nbp = 0, since_sel = 0, cur = 0;
  always #25 clk_i = ~clk_i;
  dpr_page_access uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .bp_o(bp_o), .bp_lock_o(bp_lock_o), .bp_i(bp_i), .slot_id_i(slot_id_i),
    .sub_handler_call_o(sub_call), .xfer_handler_call_o(xfer_call), .stopped_o(stopped_o));
  dpr_page_partner far (.clk_i(clk_i), .req_i(bp_o), .rsp_o(bp_i), .lat_i(lat),
    .absent_i(absent));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 50) begin
      fails++;
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask : wb
  function automatic int key(input int a);
    return (int'(pg) << 20) | (a & 'hFFFFF);
  endfunction : key
  function automatic logic [7:0] mrd(input int a);
    return mm.exists(key(a)) ? mm[key(a)] : 8'h00;
  endfunction : mrd
  task automatic op(input int o, input int k);
    int a, n, sz, lim, b0;
    logic bad, rng;
    logic [7:0] b;
    n = 0;
    bad = 0;
    rng = 0;
    cur = o;
    a = int'(base) + k;
    b0 = nbp;
    lat <= 3'($random(seed));
    wb(1, dpr_page_pkg::OFS_CMD, {16'(k), 12'h000, 4'(o)});
    if (o == 1) begin
      bad = acc1[15:0] > 16'h00FF;
      if (!bad) pg = acc1[7:0];
    end else begin
      sz = (o == 8) ? 1 : (o - 2) % 3;
      lim = (o == 8 || sz == 0) ? 'hFFBFF : (sz == 1 ? 'hFFBFE : 'hFFBFC);
      rng = a < 'hFF400 || a > lim;
      bad = rng || absent;
      if (!bad && o < 5) begin
        acc2 = acc1;
        acc1 = 0;
        for (int i = 0; i < (1 << sz); i++) acc1[8*i +: 8] = mrd(a + i);
      end else if (!bad && o < 8) begin
        for (int i = 0; i < (1 << sz); i++) mm[key(a + i)] = acc1[8*i +: 8];
      end else if (!bad) begin
        b = mrd(a);
        if (b == 0) mm[key(a)] = slot_id_i;
        st[2:1] = (b == 0) ? 2'b00 : (b == slot_id_i ? 2'b10 : 2'b01);
      end
    end
    if (bad) begin
      st[o == 1 ? 4 : 5] = 1'b1;
      if (ctrl[o != 1] && o == 1) scall++;
      else if (ctrl[o != 1]) xcall++;
      else st[3] = 1'b1;
      if (!ctrl[o != 1]) ist[o == 1] = 1'b1;
    end
    do begin
      wb(0, dpr_page_pkg::OFS_STATUS, 0);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    if (n >= 100) begin
      fails++;
      tally_and_finish();
    end
    chk(q[5:0], st, "status");
    wb(0, dpr_page_pkg::OFS_ACC1, 0);
    chk(q, acc1, "acc1");
    wb(0, dpr_page_pkg::OFS_ACC2, 0);
    chk(q, acc2, "acc2");
    wb(0, dpr_page_pkg::OFS_PAGE, 0);
    chk(q[7:0], pg, "page");
    wb(0, dpr_page_pkg::OFS_INTERRUPT_STACK, 0);
    chk(q[1:0], ist, "interrupt_stack");
    chk(stopped_o, st[3], "stopped");
    chk(ns, scall, "sub calls");
    chk(nx, xcall, "xfer calls");
    if (rng || o == 1) chk(nbp, b0, "bus cycles");
    if (bad) begin
      wb(1, dpr_page_pkg::OFS_STATUS, 32'h0000_0038);
      wb(1, dpr_page_pkg::OFS_INTERRUPT_STACK, 32'h0000_0003);
      st[5:3] = 0;
      ist = 0;
    end
    $display("Test op %0d const %0d done", o, k);
  endtask : op
  task automatic set(input logic [4:0] a, input logic [31:0] v);
    wb(1, a, v);
    if (a == dpr_page_pkg::OFS_ACC1) acc1 = v;
    if (a == dpr_page_pkg::OFS_BASE) base = v;
    if (a == dpr_page_pkg::OFS_CTRL) ctrl = v[1:0];
  endtask : set
  always @(posedge clk_i) begin
    ns += sub_call;
    nx += xfer_call;
    if (bp_o.req && !preq) nbp++;
    preq = bp_o.req;
    if (bp_o.req) chk(bp_lock_o, 1'b1, "lock");
    if (bp_o.req && bp_i.ack && bp_o.sel) begin
      chk(bp_o.wdata[7:0], pg, "select page");
      since_sel = 0;
    end else if (bp_o.req && bp_i.ack) begin
      chk(since_sel <= (cur == 8), 1'b1, "select first");
      since_sel++;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, dpr_page_pkg::OFS_PAGE, 0);
    chk(q[7:0], 8'h00, "page reset");
    set(dpr_page_pkg::OFS_CTRL, 32'h0000_0003);
    set(dpr_page_pkg::OFS_BASE, 32'h000F_F400);
    set(dpr_page_pkg::OFS_ACC1, 32'($random(seed)) & 32'h0000_00FF);
    op(1, 0);
    // Last legal place and one past it, for each access size
    for (int s = 0; s < 3; s++) begin
      set(dpr_page_pkg::OFS_ACC1, 32'($random(seed)));
      op(5 + s, 'h7FF - (s == 2 ? 3 : s));
      set(dpr_page_pkg::OFS_ACC1, 32'($random(seed)));
      op(2 + s, 'h7FF - (s == 2 ? 3 : s));
      op(2 + s, 'h800 - (s == 2 ? 3 : s));
      op(5 + s, -1);
    end
    set(dpr_page_pkg::OFS_BASE, 32'h000F_FC00);
    op(2, -1);
    op(2, -32768);
    set(dpr_page_pkg::OFS_BASE, 32'h000F_F400);
    set(dpr_page_pkg::OFS_ACC1, 32'h0000_0100);
    op(1, 0);
    set(dpr_page_pkg::OFS_CTRL, 32'h0000_0000);
    set(dpr_page_pkg::OFS_ACC1, 32'h0000_FFFF);
    op(1, 0);
    set(dpr_page_pkg::OFS_ACC1, 32'($random(seed)) & 32'h0000_00FF);
    op(1, 0);
    op(4, 'h7FC);
    op(8, 'h10);
    op(8, 'h10);
    slot_id_i <= 8'h2A;
    op(8, 'h10);
    set(dpr_page_pkg::OFS_ACC1, 32'h0000_0000);
    op(6, 'h10);
    op(8, 'h10);
    op(8, -1);
    absent <= 1'b1;
    op(3, 0);
    set(dpr_page_pkg::OFS_CTRL, 32'h0000_0003);
    op(8, 0);
    absent <= 1'b0;
    op(3, 0);
    // A reset in mid-run brings the page register back to zero
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    acc1 = 0;
    acc2 = 0;
    base = 0;
    pg = 0;
    ctrl = 0;
    st = 0;
    ist = 0;
    wb(0, dpr_page_pkg::OFS_PAGE, 0);
    chk(q[7:0], 8'h00, "page after reset");
    set(dpr_page_pkg::OFS_BASE, 32'h000F_F400);
    op(2, 'h20);
    $display("Test mid-run reset done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
